/* File: rtl/eiss_evsync.v */
// Event input synchroniser and debouncer.
`timescale 1ns/1ps
`default_nettype none
module eiss_evsync #(
  parameter DEB_CYCLES = 250000
) (
  input  wire clk_i,
  input  wire resetn_i,
  input  wire evt_i,
  output wire level_o
);
  // Two flip-flop synchroniser; only sync_q reads meta_q.
  reg        meta_q;
  reg        sync_q;
  reg        level_q;  // Debounced level.
  reg [31:0] cnt_q;    // Stability counter.

  // A change must hold for DEB_CYCLES before it is accepted, so contact bounce never toggles the function.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      meta_q  <= 1'b0;
      sync_q  <= 1'b0;
      level_q <= 1'b0;
      cnt_q   <= 32'h0;
    end else begin
      meta_q <= evt_i;
      sync_q <= meta_q;
      if (sync_q == level_q) begin
        cnt_q <= 32'h0;
      end else if (cnt_q >= DEB_CYCLES - 1) begin
        level_q <= sync_q;
        cnt_q   <= 32'h0;
      end else begin
        cnt_q <= cnt_q + 32'h1;
      end
    end
  end

  assign level_o = level_q;
endmodule // eiss_evsync
`default_nettype wire

/* File: rtl/eiss_map.vh */
// Register offsets, field positions, codes and timing figures of the event input block.
`ifndef EISS_MAP_VH
`define EISS_MAP_VH
// Data and address widths of the register port.
`define EISS_DW 16
`define EISS_AW 4
// Register offsets.
`define EISS_A_CFG 4'h0
`define EISS_A_SP1 4'h1
`define EISS_A_SP2 4'h2
`define EISS_A_RAMP 4'h3
`define EISS_A_DWELL 4'h4
`define EISS_A_PB1 4'h5
`define EISS_A_TI1 4'h6
`define EISS_A_TD1 4'h7
`define EISS_A_PB2 4'h8
`define EISS_A_TI2 4'h9
`define EISS_A_TD2 4'ha
`define EISS_A_STAT 4'hb
`define EISS_A_WSP 4'hc
// Configuration fields.
`define EISS_F_EFS 3:0
`define EISS_F_MODE 5:4
`define EISS_B_FMT 6
`define EISS_B_A1T 7
`define EISS_B_A2T 8
// Event function codes.
`define EISS_FN_NONE 4'h0
`define EISS_FN_SP2 4'h1
`define EISS_FN_TUNING_BANK_SWAP 4'h2
`define EISS_FN_SPP2 4'h3
`define EISS_FN_RSA1 4'h4
`define EISS_FN_RSA2 4'h5
`define EISS_FN_RSA12 4'h6
`define EISS_FN_DO1 4'h7
`define EISS_FN_DO2 4'h8
`define EISS_FN_DO12 4'h9
`define EISS_FN_LOCK 4'ha
// Set point source modes.
`define EISS_MD_PAIR 2'h0
`define EISS_MD_MIN 2'h1
`define EISS_MD_HR 2'h2
// Reset values.
`define EISS_RST_VAL 16'h0000
// Timing: base tick in seconds, clock in MHz, debounce in microseconds.
`define EISS_TICK_S 1
`define EISS_CLK_MHZ 250
`define EISS_DEB_US 1000
`define EISS_SUB_LAST 6'h3b
`endif

/* File: rtl/eiss_ramp.v */
// Set point ramp generator stepping toward the target.
`timescale 1ns/1ps
`default_nettype none
module eiss_ramp (
  input  wire        clk_i,
  input  wire        resetn_i,
  input  wire        en_i,
  input  wire        load_i,
  input  wire        tick_i,
  input  wire [15:0] target_i,
  input  wire [15:0] pv_i,
  input  wire [15:0] rate_i,
  output wire [15:0] work_o
);
  reg  [15:0] work_q;  // Current ramping value.
  wire [16:0] up  = {1'b0, work_q} + {1'b0, rate_i};
  wire [16:0] gap_up = {1'b0, target_i} - {1'b0, work_q};
  wire [16:0] gap_dn = {1'b0, work_q} - {1'b0, target_i};

  // Rate zero or ramp off passes the target straight through.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      work_q <= 16'h0000;
    end else if (!en_i || rate_i == 16'h0000) begin
      work_q <= target_i;
    end else if (load_i) begin
      work_q <= pv_i;
    end else if (tick_i) begin
      // Clamp at the target so the last step never overshoots.
      if (work_q < target_i) begin
        work_q <= (gap_up <= {1'b0, rate_i}) ? target_i : up[15:0];
      end else if (work_q > target_i) begin
        work_q <= (gap_dn <= {1'b0, rate_i}) ? target_i : work_q - rate_i;
      end
    end
  end

  assign work_o = work_q;
endmodule // eiss_ramp
`default_nettype wire

/* File: rtl/eiss_top.v */
// Event input function select, set point and tuning bank selection, ramp and dwell timer.
//
// Summary of operation
// - Four-bit function code selects eleven behaviours.
// - Code zero: first bank, input ignored.
// - Code one: second set point while active.
// - Code two: second tuning set while active.
// - Code three: set point and tuning swap together.
// - Tuning results go to the selected bank.
// - Codes four, five reset one alarm each.
// - Code six resets both alarms.
// - Code seven zeroes output one demand.
// - Code eight zeroes output two demand.
// - Code nine zeroes both demands at once.
// - Outputs resume control on input release.
// - Code ten blocks all register writes.
// - Offset format adds first and second set points.
// - Second set point only in pair/ramp modes.
// - Ramp modes ramp on set point and rate changes.
// - Ramp restarts from process value on change.
// - Zero rate applies the set point at once.
// - Timer counts from set point reach, then alarms.
// - Dwell change never restarts the running count.
// - Timer alarm holds until alarm reset event.
// - Timer on both alarms is refused, flagged.
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "eiss_map.vh"
module eiss_top #(
  parameter TICK_CYCLES = `EISS_TICK_S * `EISS_CLK_MHZ * 1000000,
  parameter DEB_CYCLES  = `EISS_DEB_US * `EISS_CLK_MHZ
) (
  input  wire        clk_i,
  input  wire        resetn_i,
  // Register port.
  input  wire [3:0]  addr_i,
  input  wire [15:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output wire [15:0] rdata_o,
  // Event input pin.
  input  wire        event_pin_i,
  // Process value and control stage.
  input  wire [15:0] pv_i,
  input  wire [15:0] out1_demand_i,
  input  wire [15:0] out2_demand_i,
  input  wire        alarm1_cond_i,
  input  wire        alarm2_cond_i,
  // Auto-tune / self-tune result strobe.
  input  wire        tune_wr_i,
  input  wire [15:0] tune_band_i,
  input  wire [15:0] tune_int_i,
  input  wire [15:0] tune_der_i,
  // Selected values toward the control stage.
  output wire [15:0] setpoint_o,
  output wire [15:0] band_o,
  output wire [15:0] integral_o,
  output wire [15:0] derivative_o,
  output wire [15:0] out1_demand_o,
  output wire [15:0] out2_demand_o,
  output wire        alarm1_o,
  output wire        alarm2_o,
  output wire        param_lock_o,
  output wire        cfg_error_o
);
  // ****************
  // Registers
  // ****************
  reg [15:0] cfg_q;       // Function, mode, format, timer bits.
  reg [15:0] sp1_q;       // First set point.
  reg [15:0] sp2_q;       // Second set point.
  reg [15:0] rate_q;      // Ramp rate per minute or hour.
  reg [15:0] dwell_q;     // Dwell time in minutes.
  reg [15:0] bank_q [0:5]; // Tuning banks: first three, second three.
  reg        err_q;       // Last configuration write refused.
  reg [15:0] rdata_q;     // Read data, one cycle after the strobe.

  // ****************
  // Decoded configuration
  // ****************
  wire [3:0] efs  = cfg_q[`EISS_F_EFS];
  wire [1:0] mode = cfg_q[`EISS_F_MODE];
  wire       fmt  = cfg_q[`EISS_B_FMT];
  wire       a1t  = cfg_q[`EISS_B_A1T];
  wire       a2t  = cfg_q[`EISS_B_A2T];

  // ****************
  // Event input
  // ****************
  wire ev;  // Debounced, level-sensitive event.

  // The pin is asynchronous; it is synchronised and debounced first.
  eiss_evsync #(
    .DEB_CYCLES (DEB_CYCLES)
  ) u_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .evt_i    (event_pin_i),
    .level_o  (ev)
  );

  // Function decode; every effect lasts only while the event is active.
  wire sp2_fn  = (efs == `EISS_FN_SP2) || (efs == `EISS_FN_SPP2);
  wire pid_fn  = (efs == `EISS_FN_TUNING_BANK_SWAP) || (efs == `EISS_FN_SPP2);
  wire rs1_fn  = (efs == `EISS_FN_RSA1) || (efs == `EISS_FN_RSA12);
  wire rs2_fn  = (efs == `EISS_FN_RSA2) || (efs == `EISS_FN_RSA12);
  wire do1_fn  = (efs == `EISS_FN_DO1) || (efs == `EISS_FN_DO12);
  wire do2_fn  = (efs == `EISS_FN_DO2) || (efs == `EISS_FN_DO12);
  wire lock_fn = (efs == `EISS_FN_LOCK);

  // Remote mode has no second set point, so the swap is gated by mode.
  wire mode_ok = (mode == `EISS_MD_PAIR) || (mode == `EISS_MD_MIN) ||
                 (mode == `EISS_MD_HR);
  wire use_sp2 = ev && sp2_fn && mode_ok;
  wire use_b2  = ev && pid_fn;
  wire rst1    = ev && rs1_fn;
  wire rst2    = ev && rs2_fn;
  wire dis1    = ev && do1_fn;
  wire dis2    = ev && do2_fn;
  wire locked  = ev && lock_fn;

  // ****************
  // Set point selection
  // ****************
  // Offset format sums both set points; the carry is dropped.
  wire [16:0] sp_sum = {1'b0, sp1_q} + {1'b0, sp2_q};
  wire [15:0] sp2_eff = fmt ? sp_sum[15:0] : sp2_q;
  wire [15:0] target = use_sp2 ? sp2_eff : sp1_q;

  // ****************
  // Minute and hour ticks
  // ****************
  reg [31:0] cyc_q;   // Cycles within a second.
  reg [5:0]  sec_q;   // Seconds within a minute.
  reg [5:0]  min_q;   // Minutes within an hour.
  wire sec_tick = (cyc_q >= TICK_CYCLES - 1);
  wire min_tick = sec_tick && (sec_q == `EISS_SUB_LAST);
  wire hr_tick  = min_tick && (min_q == `EISS_SUB_LAST);

  // Free-running time base shared by ramp and dwell timer.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      cyc_q <= 32'h0;
      sec_q <= 6'h00;
      min_q <= 6'h00;
    end else begin
      cyc_q <= sec_tick ? 32'h0 : cyc_q + 32'h1;
      if (sec_tick) begin
        sec_q <= (sec_q == `EISS_SUB_LAST) ? 6'h00 : sec_q + 6'h01;
      end
      if (min_tick) begin
        min_q <= (min_q == `EISS_SUB_LAST) ? 6'h00 : min_q + 6'h01;
      end
    end
  end

  // ****************
  // Ramp
  // ****************
  reg        init_q;     // High for the first cycle after reset.
  reg [15:0] tgt_prev_q; // Target seen last cycle.
  reg [15:0] rate_prev_q; // Rate seen last cycle.
  wire       ramp_en = (mode == `EISS_MD_MIN) || (mode == `EISS_MD_HR);
  wire       ramp_tick = (mode == `EISS_MD_HR) ? hr_tick : min_tick;
  // Any change of set point or rate restarts the ramp; at power-up the reset mode and zero rate leave ramping off.
  wire       ramp_load = init_q || (tgt_prev_q != target) ||
                         (rate_prev_q != rate_q);
  wire [15:0] work;

  // Change detection history.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      init_q      <= 1'b1;
      tgt_prev_q  <= `EISS_RST_VAL;
      rate_prev_q <= `EISS_RST_VAL;
    end else begin
      init_q      <= 1'b0;
      tgt_prev_q  <= target;
      rate_prev_q <= rate_q;
    end
  end

  eiss_ramp u_ramp (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .en_i     (ramp_en),
    .load_i   (ramp_load),
    .tick_i   (ramp_tick),
    .target_i (target),
    .pv_i     (pv_i),
    .rate_i   (rate_q),
    .work_o   (work)
  );

  // ****************
  // Dwell timer
  // ****************
  reg        run_q;   // Counting since the set point was reached.
  reg        done_q;  // Timed out, held until an alarm reset.
  reg [15:0] tcnt_q;  // Elapsed minutes.
  wire       tmr_en  = a1t || a2t;
  // The reset of whichever channel carries the timer clears it.
  wire       tmr_rst = (a1t && rst1) || (a2t && rst2);

  // The count compares against the live dwell value, so edits never restart it.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      run_q  <= 1'b0;
      done_q <= 1'b0;
      tcnt_q <= 16'h0000;
    end else if (!tmr_en || tmr_rst) begin
      run_q  <= 1'b0;
      done_q <= 1'b0;
      tcnt_q <= 16'h0000;
    end else if (!run_q && !done_q) begin
      if (pv_i >= target) begin
        run_q <= 1'b1;
      end
    end else if (run_q) begin
      if (tcnt_q >= dwell_q) begin
        run_q  <= 1'b0;
        done_q <= 1'b1;
      end else if (min_tick) begin
        tcnt_q <= tcnt_q + 16'h0001;
      end
    end
  end

  // ****************
  // Alarms
  // ****************
  reg al1_q;  // Alarm one output.
  reg al2_q;  // Alarm two output.

  // A held reset keeps the alarm low; a persisting condition sets it on release.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      al1_q <= 1'b0;
      al2_q <= 1'b0;
    end else begin
      if (a1t) begin
        al1_q <= done_q;
      end else begin
        al1_q <= !rst1 && (al1_q || alarm1_cond_i);
      end
      if (a2t) begin
        al2_q <= done_q;
      end else begin
        al2_q <= !rst2 && (al2_q || alarm2_cond_i);
      end
    end
  end

  // ****************
  // Outputs toward the control stage
  // ****************
  reg [15:0] sp_q;    // Working set point.
  reg [15:0] pb_q;    // Active band.
  reg [15:0] ti_q;    // Active integral time.
  reg [15:0] td_q;    // Active derivative time.
  reg [15:0] o1_q;    // Output one demand.
  reg [15:0] o2_q;    // Output two demand.
  reg        lock_q;  // Parameters locked.

  // Demands are forced to zero only while the event holds.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      sp_q   <= `EISS_RST_VAL;
      pb_q   <= `EISS_RST_VAL;
      ti_q   <= `EISS_RST_VAL;
      td_q   <= `EISS_RST_VAL;
      o1_q   <= `EISS_RST_VAL;
      o2_q   <= `EISS_RST_VAL;
      lock_q <= 1'b0;
    end else begin
      sp_q   <= work;
      pb_q   <= use_b2 ? bank_q[3] : bank_q[0];
      ti_q   <= use_b2 ? bank_q[4] : bank_q[1];
      td_q   <= use_b2 ? bank_q[5] : bank_q[2];
      o1_q   <= dis1 ? `EISS_RST_VAL : out1_demand_i;
      o2_q   <= dis2 ? `EISS_RST_VAL : out2_demand_i;
      lock_q <= locked;
    end
  end

  // ****************
  // Register writes
  // ****************
  // Writes are taken only while no lock applies.
  wire wr_ok  = wr_i && !locked;
  wire bad_tm = wdata_i[`EISS_B_A1T] && wdata_i[`EISS_B_A2T];

  // Configuration and set point registers.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      cfg_q   <= `EISS_RST_VAL;
      sp1_q   <= `EISS_RST_VAL;
      sp2_q   <= `EISS_RST_VAL;
      rate_q  <= `EISS_RST_VAL;
      dwell_q <= `EISS_RST_VAL;
      err_q   <= 1'b0;
    end else if (wr_ok) begin
      case (addr_i)
        `EISS_A_CFG: begin
          // A timer on both channels is refused and flagged.
          if (bad_tm) begin
            err_q <= 1'b1;
          end else begin
            cfg_q <= wdata_i;
            err_q <= 1'b0;
          end
        end
        `EISS_A_SP1:   sp1_q   <= wdata_i;
        `EISS_A_SP2:   sp2_q   <= wdata_i;
        `EISS_A_RAMP:  rate_q  <= wdata_i;
        `EISS_A_DWELL: dwell_q <= wdata_i;
        default: begin
          // Bank and read-only offsets are handled elsewhere.
        end
      endcase
    end
  end

  // Tuning banks: tuning results beat a software write in the same cycle.
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_bank
      wire hi   = (g >= 3);
      wire tsel = tune_wr_i && (hi == use_b2);
      wire swr  = wr_ok && (addr_i == `EISS_A_PB1 + g[3:0]);
      wire [15:0] tval = (g % 3 == 0) ? tune_band_i :
                         (g % 3 == 1) ? tune_int_i : tune_der_i;
      always @(posedge clk_i) begin
        if (!resetn_i) begin
          bank_q[g] <= `EISS_RST_VAL;
        end else if (tsel) begin
          bank_q[g] <= tval;
        end else if (swr) begin
          bank_q[g] <= wdata_i;
        end
      end
    end
  endgenerate

  // ****************
  // Register reads
  // ****************
  wire [15:0] stat = {7'h00, done_q, run_q, al2_q, al1_q, err_q,
                      locked, use_b2, use_sp2, ev};
  reg  [15:0] rmux;  // Selected read value.

  // Unmapped offsets read as zero.
  always @* begin
    rmux = 16'h0000;
    case (addr_i)
      `EISS_A_CFG:   rmux = cfg_q;
      `EISS_A_SP1:   rmux = sp1_q;
      `EISS_A_SP2:   rmux = sp2_q;
      `EISS_A_RAMP:  rmux = rate_q;
      `EISS_A_DWELL: rmux = dwell_q;
      `EISS_A_PB1:   rmux = bank_q[0];
      `EISS_A_TI1:   rmux = bank_q[1];
      `EISS_A_TD1:   rmux = bank_q[2];
      `EISS_A_PB2:   rmux = bank_q[3];
      `EISS_A_TI2:   rmux = bank_q[4];
      `EISS_A_TD2:   rmux = bank_q[5];
      `EISS_A_STAT:  rmux = stat;
      `EISS_A_WSP:   rmux = sp_q;
      default:       rmux = 16'h0000;
    endcase
  end

  // Read data stands for exactly the cycle after the strobe.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rd_i ? rmux : 16'h0000;
    end
  end

  // ****************
  // Output connections
  // ****************
  assign rdata_o       = rdata_q;
  assign setpoint_o    = sp_q;
  assign band_o        = pb_q;
  assign integral_o    = ti_q;
  assign derivative_o  = td_q;
  assign out1_demand_o = o1_q;
  assign out2_demand_o = o2_q;
  assign alarm1_o      = al1_q;
  assign alarm2_o      = al2_q;
  assign param_lock_o  = lock_q;
  assign cfg_error_o   = err_q;
endmodule // eiss_top
`default_nettype wire

/* File: test/eiss_contact.sv */
// Model of the external contact that drives the event input.
`timescale 1ns/1ps
`default_nettype none
module eiss_contact #(
  parameter int BOUNCE = 2
) (
  input  wire logic clk_i,
  input  wire logic level_i,
  output var  logic pin_o
);
  logic       want_q; // Level the contact settles to.
  logic [3:0] chat_q; // Chatter cycles still to come.
  initial begin
    pin_o = 1'b0;
    want_q = 1'b0;
    chat_q = 4'h0;
  end
  // Chatter follows each change, shorter than the debounce.
  always @(posedge clk_i) begin
    if (level_i != want_q) begin
      want_q <= level_i;
      chat_q <= 4'(BOUNCE);
      pin_o <= level_i;
    end else if (chat_q != 4'h0) begin
      chat_q <= chat_q - 4'h1;
      pin_o <= ~pin_o;
    end else begin
      pin_o <= want_q;
    end
  end
endmodule // eiss_contact
`default_nettype wire

/* File: test/eiss_top_chk.sv */
// Port-level assertions for the event input selection block.
`timescale 1ns/1ps
`default_nettype none
`include "eiss_map.vh"
module eiss_top_chk #(
  parameter int DEB_CYCLES = 3
) (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic [3:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic        event_pin_i,
  input wire logic [15:0] out1_demand_i,
  input wire logic [15:0] out1_demand_o,
  input wire logic [15:0] out2_demand_o,
  input wire logic        alarm1_cond_i,
  input wire logic        alarm1_o,
  input wire logic        alarm2_o,
  input wire logic        param_lock_o,
  input wire logic        cfg_error_o
);
  // ****************
  // Helper logic
  // ****************
  // Margin covers two sync flops, the debounce and one output register.
  localparam int SETTLE = DEB_CYCLES + 5;
  logic [15:0] hi_q;    // Cycles the pin has been steadily high.
  logic [15:0] lo_q;    // Cycles the pin has been steadily low.
  logic [8:0]  cfg_q;   // Mirror of the accepted configuration word.
  logic [3:0]  quiet_q; // Cycles since the last configuration write.
  logic [3:0]  fn;      // Event function code from the mirror.
  logic        on_w;    // Event surely seen active by the block.
  logic        off_w;   // Event surely seen released by the block.
  assign fn = cfg_q[3:0];
  assign on_w = hi_q >= SETTLE && quiet_q > 4'h3;
  assign off_w = lo_q >= SETTLE && quiet_q > 4'h3;
  // Track the pin and the configuration; refused writes leave the mirror alone.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      hi_q <= 16'h0;
      lo_q <= 16'h0;
      cfg_q <= 9'h0;
      quiet_q <= 4'h0;
    end else begin
      hi_q <= event_pin_i ? hi_q + {15'h0, hi_q != 16'hffff} : 16'h0;
      lo_q <= !event_pin_i ? lo_q + {15'h0, lo_q != 16'hffff} : 16'h0;
      quiet_q <= quiet_q + {3'h0, quiet_q != 4'hf};
      if (wr_i && addr_i == `EISS_A_CFG) begin
        quiet_q <= 4'h0;
        if (!param_lock_o && wdata_i[8:7] != 2'h3) begin
          cfg_q <= wdata_i[8:0];
        end
      end
    end
  end
  // ****************
  // Assertions
  // ****************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  out1_zero_a: assert property (on_w && (fn == `EISS_FN_DO1 || fn == `EISS_FN_DO12) |-> out1_demand_o == 16'h0)
    else $error("output one demand not cleared");
  out2_zero_a: assert property (on_w && (fn == `EISS_FN_DO2 || fn == `EISS_FN_DO12) |-> out2_demand_o == 16'h0)
    else $error("output two demand not cleared");
  demand_pass_a: assert property (off_w |-> out1_demand_o == $past(out1_demand_i))
    else $error("demand one not passed");
  lock_level_a: assert property (on_w || off_w |-> param_lock_o == (on_w && fn == `EISS_FN_LOCK))
    else $error("lock flag wrong");
  timer_both_a: assert property (wr_i && addr_i == `EISS_A_CFG && wdata_i[8:7] == 2'h3 && !param_lock_o |=> cfg_error_o)
    else $error("dual timer not flagged");
  alarm1_clr_a: assert property (on_w && (fn == `EISS_FN_RSA1 || fn == `EISS_FN_RSA12) |-> !alarm1_o)
    else $error("alarm one not reset");
  alarm2_clr_a: assert property (on_w && (fn == `EISS_FN_RSA2 || fn == `EISS_FN_RSA12) |-> !alarm2_o)
    else $error("alarm two not reset");
  alarm_retrig_a: assert property (off_w && alarm1_cond_i && !cfg_q[7] |-> ##[0:2] alarm1_o)
    else $error("alarm one not set");
  timer_hold_a: assert property (cfg_q[7] && alarm1_o && off_w && !(wr_i && addr_i == `EISS_A_CFG) |=> alarm1_o)
    else $error("timer alarm dropped");
  cfg_read_a: assert property (rd_i && addr_i == `EISS_A_CFG |=> rdata_o[8:0] == cfg_q)
    else $error("config read wrong");
  // Main scenarios reached.
  cover property (on_w && fn == `EISS_FN_LOCK);
  cover property (on_w && fn == `EISS_FN_DO12);
  cover property ($rose(cfg_error_o));
  cover property (cfg_q[7] && $rose(alarm1_o));
endmodule // eiss_top_chk
bind eiss_top eiss_top_chk #(.DEB_CYCLES(DEB_CYCLES)) u_chk (.*);
`default_nettype wire

/* File: test/test_event_input_setpoint_select.sv */
// Self-checking bench for the event input selection block.
`timescale 1ns/1ps
`default_nettype none
`include "eiss_map.vh"
module test_event_input_setpoint_select;
  localparam int DEB = 3;      // Short debounce keeps the run brief.
  localparam int W = DEB + 10; // Wait after an event edge.
  logic        clk, resetn, wr, rd, req, pin, c1, c2, tw, a1, a2, lock, cerr, fm;
  logic [1:0]  m;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata, pv, d1, d2, tband, tint, tder, sp, band, integ, deriv, o1, o2, r, t, rt;
  logic [15:0] rv [0:10];
  int          n_fail = 0;
  int          checks_done = 0;
  int          f, e, j, x;
  eiss_top #(.TICK_CYCLES(4), .DEB_CYCLES(DEB)) DUT (
    .clk_i(clk), .resetn_i(resetn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .event_pin_i(pin), .pv_i(pv), .out1_demand_i(d1), .out2_demand_i(d2),
    .alarm1_cond_i(c1), .alarm2_cond_i(c2), .tune_wr_i(tw), .tune_band_i(tband), .tune_int_i(tint),
    .tune_der_i(tder), .setpoint_o(sp), .band_o(band), .integral_o(integ), .derivative_o(deriv),
    .out1_demand_o(o1), .out2_demand_o(o2), .alarm1_o(a1), .alarm2_o(a2), .param_lock_o(lock),
    .cfg_error_o(cerr));
  eiss_contact #(.BOUNCE(2)) u_contact (.clk_i(clk), .level_i(req), .pin_o(pin));
  // ****************
  // Tasks
  // ****************
  // Compare one value; an unknown never matches.
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] ex);
    checks_done++;
    if (s !== ex) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, ex, s);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe.
  task automatic rreg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk) begin addr <= a; rd <= 1'b1; end
    @(posedge clk) rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic ev(input logic l);
    @(posedge clk) req <= l;
    wt(W);
  endtask
  // Strobe random tuning results and read them back from the given bank.
  task automatic tune(input logic [3:0] a);
    @(posedge clk) begin tband <= 16'($urandom); tint <= 16'($urandom); tder <= 16'($urandom); tw <= 1'b1; end
    @(posedge clk) tw <= 1'b0;
    rreg(a, r); chk("tuned band", r, tband);
    rreg(a + 4'h1, r); chk("tuned integral", r, tint);
    rreg(a + 4'h2, r); chk("tuned derivative", r, tder);
  endtask
  task automatic summarize;
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Working set point expected with ramping off.
  function automatic logic [15:0] exp_sp(input int f, input logic fm, input int e, input logic [15:0] s1, s2);
    if (e == 1 && (f == 1 || f == 3)) return fm ? s1 + s2 : s2;
    return s1;
  endfunction
  // ****************
  // Sequence
  // ****************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Watchdog far above the expected run.
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    summarize();
  end
  initial begin
    {resetn, wr, rd, req, tw, c1, c2} = 7'h0;
    {addr, wdata, pv, d1, d2, tband, tint, tder} = '0;
    void'($urandom(13));
    wt(5);
    chk("setpoint in reset", sp, 16'h0);
    @(posedge clk) resetn <= 1'b1;
    for (j = 0; j < 11; j++) begin rreg(j[3:0], r); chk("reset value", r, 16'h0); end
    rreg(4'hf, r); chk("unmapped read", r, 16'h0);
    // Every function code, event applied and then released.
    for (f = 0; f < 11; f++) begin
      for (j = 1; j < 11; j++) begin rv[j] = (j == 3) ? 16'h0 : 16'($urandom); wreg(j[3:0], rv[j]); end
      m = 2'($urandom_range(2, 0));
      fm = 1'($urandom_range(1, 0));
      rv[0] = {9'h0, fm, m, f[3:0]};
      wreg(`EISS_A_CFG, rv[0]);
      d1 <= 16'($urandom); d2 <= 16'($urandom); c1 <= 1'b1; c2 <= 1'b1;
      for (j = 0; j < 11; j++) begin rreg(j[3:0], r); chk("readback", r, rv[j]); end
      for (e = 1; e >= 0; e--) begin
        ev(e[0]);
        x = (e == 1 && (f == 2 || f == 3)) ? 3 : 0;
        chk("setpoint", sp, exp_sp(f, fm, e, rv[1], rv[2]));
        chk("band", band, rv[5 + x]);
        chk("integral", integ, rv[6 + x]);
        chk("derivative", deriv, rv[7 + x]);
        chk("demand one", o1, (e == 1 && (f == 7 || f == 9)) ? 16'h0 : d1);
        chk("demand two", o2, (e == 1 && (f == 8 || f == 9)) ? 16'h0 : d2);
        chk("alarm one", {15'h0, a1}, {15'h0, !(e == 1 && (f == 4 || f == 6))});
        chk("alarm two", {15'h0, a2}, {15'h0, !(e == 1 && (f == 5 || f == 6))});
        chk("lock", {15'h0, lock}, {15'h0, e == 1 && f == 10});
        if (e == 1) begin
          wreg(`EISS_A_SP1, ~rv[1]);
          rreg(`EISS_A_SP1, r);
          if (f != 10) rv[1] = ~rv[1];
          chk("locked write", r, rv[1]);
        end
      end
    end
    // A pulse shorter than the debounce span changes nothing.
    wreg(`EISS_A_CFG, 16'h0007);
    @(posedge clk) req <= 1'b1;
    @(posedge clk) req <= 1'b0;
    wt(W);
    chk("glitch", o1, d1);
    // Both alarm channels as timers is refused.
    wreg(`EISS_A_CFG, 16'h0187);
    wt(1);
    chk("config error", {15'h0, cerr}, 16'h1);
    rreg(`EISS_A_CFG, r); chk("refused config", r, 16'h0007);
    rreg(`EISS_A_STAT, r); chk("status error", {15'h0, r[4]}, 16'h1);
    // Per-minute ramp from the process value, clamped at the target.
    pv <= 16'($urandom_range(255, 0));
    rt = 16'($urandom_range(40, 1));
    wreg(`EISS_A_CFG, 16'h0010);
    wt(1);
    chk("error cleared", {15'h0, cerr}, 16'h0);
    t = pv + 2 * rt + 16'h1;
    wreg(`EISS_A_RAMP, rt);
    wreg(`EISS_A_SP1, t);
    wt(3);
    chk("ramp start", sp, pv);
    for (j = 0; j < 300 && sp === pv; j++) wt(1);
    chk("ramp step", sp, pv + rt);
    wt(490);
    chk("ramp end", sp, t);
    wreg(`EISS_A_RAMP, 16'h0);
    wreg(`EISS_A_SP1, t + 16'h100);
    wt(3);
    chk("zero rate", sp, t + 16'h100);
    // Tuning results land in the bank in use.
    wreg(`EISS_A_CFG, 16'h0002);
    ev(1'b1);
    tune(`EISS_A_PB2);
    ev(1'b0);
    tune(`EISS_A_PB1);
    // Clear the latched alarm, then run the dwell timer.
    wreg(`EISS_A_CFG, 16'h0004);
    c1 <= 1'b0;
    c2 <= 1'b0;
    ev(1'b1);
    ev(1'b0);
    pv <= 16'h0080;
    wreg(`EISS_A_SP1, 16'h0100);
    wreg(`EISS_A_DWELL, 16'h0003);
    wreg(`EISS_A_CFG, 16'h0084);
    wt(300);
    chk("timer idle", {15'h0, a1}, 16'h0);
    pv <= 16'h0100;
    wt(100);
    wreg(`EISS_A_DWELL, 16'h0005);
    wt(800);
    chk("timer extended", {15'h0, a1}, 16'h0);
    wt(320);
    chk("timer done", {15'h0, a1}, 16'h1);
    pv <= 16'h0;
    wt(20);
    chk("timer held", {15'h0, a1}, 16'h1);
    ev(1'b1);
    chk("timer reset", {15'h0, a1}, 16'h0);
    ev(1'b0);
    chk("timer stays reset", {15'h0, a1}, 16'h0);
    summarize();
  end
endmodule // test_event_input_setpoint_select
`default_nettype wire
